// ---- rtl/epm_regs.sv ----
// apb register bank: interrupt signalling config, event status and pm capability header
//
// Behaviour
// - action field: 0 masked, 1 msi, 2 inta, 4 intc, 5 intd, 6-7 reserved
// - act when status sets; legacy mode also sends negation when status clears
// - msi only sent while msi enable bit is set
// - intx messages only sent while legacy interrupt disable is clear
// - msi carries traffic class from bits 31:29, reset zero
// - pm header low byte reads capability id one, ignores writes
// - next capability pointer reads zero, last entry
// - pm version field reads two
// - power event clock bit 19 and reserved bit 20 read zero
// - device specific init bit 21 resets zero, writable only when unlocked
// - aux current field reads zero
// - d1 and d2 support bits read zero
// - power event support field reads zero
`timescale 1ns/1ps
`include "epm_params.svh"
module epm_regs (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        far_power_change,
   output logic             irq,
   output logic             msi_req,
   output logic      [2:0]  msi_tc,
   output logic             intx_assert,
   output logic             intx_deassert,
   output logic      [1:0]  intx_pin
);
   epm_pkg::epm_regs_t r_q;
   epm_pkg::epm_regs_t r_d;

   logic        evt_pulse;
   logic        setup_ph;
   logic        access_ph;
   logic        hit;
   logic        wr_en;
   logic [31:0] rd_val;
   logic [31:0] cfg_word;
   logic [31:0] pmcap_word;
   logic [31:0] ctrl_word;

   epm_msg_if msg ();

   // pin event crosses into pclk before anything looks at it
   epm_sync epm_sync_inst (
      .pclk       (pclk),
      .presetn    (presetn),
      .async_in   (far_power_change),
      .rise_pulse (evt_pulse)
   );

   epm_msg_gen epm_msg_gen_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .m       (msg.gen)
   );

   // apb phases; the slave never inserts wait states
   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign pready    = 1'b1;

   // address decode over the six mapped words
   always_comb begin
      case (paddr)
         `EPM_OFF_PMCAP,
         `EPM_OFF_ISCFG,
         `EPM_OFF_ISTS,
         `EPM_OFF_ICLR,
         `EPM_OFF_IEN,
         `EPM_OFF_CTRL: hit = 1'b1;
         default:       hit = 1'b0;
      endcase
   end

   // unmapped addresses answer with an error and leave state alone
   assign pslverr = access_ph & ~hit;
   assign wr_en   = access_ph & pwrite & hit;

   // reserved config bits and unimplemented low fields read zero
   always_comb begin
      cfg_word                               = 32'h0000_0000;
      cfg_word[`EPM_ACT_MSB:`EPM_ACT_LSB]    = r_q.action;
      cfg_word[`EPM_TC_MSB:`EPM_TC_LSB]      = r_q.tc;
   end

   always_comb begin
      pmcap_word                 = 32'h0000_0000;
      pmcap_word[7:0]               = `EPM_CAP_IDENT;
      pmcap_word[15:8]              = `EPM_NEXT_PTR;
      pmcap_word[18:16]             = `EPM_PMVER;
      pmcap_word[`EPM_DEV_INIT_BIT] = r_q.dev_init;
   end

   // control word: msi enable, legacy disable, header unlock
   always_comb begin
      ctrl_word                     = 32'h0000_0000;
      ctrl_word[`EPM_CTRL_MSI_EN]   = r_q.msi_en;
      ctrl_word[`EPM_CTRL_INTX_DIS] = r_q.intx_dis;
      ctrl_word[`EPM_CTRL_UNLOCK]   = r_q.unlock;
   end

   // read mux; the clear register is write-only and reads zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (paddr)
         `EPM_OFF_PMCAP: rd_val = pmcap_word;
         `EPM_OFF_ISCFG: rd_val = cfg_word;
         `EPM_OFF_ISTS:  rd_val[`EPM_EVT_BIT] = r_q.status;
         `EPM_OFF_IEN:   rd_val[`EPM_EVT_BIT] = r_q.enable;
         `EPM_OFF_CTRL:  rd_val = ctrl_word;
         default:        rd_val = 32'h0000_0000;
      endcase
   end

   // next state of the whole bank
   always_comb begin
      r_d = r_q;
      // read data is captured in the setup cycle so prdata is a flop yet needs no wait
      if (setup_ph && !pwrite) begin
         r_d.prdata = rd_val;
      end
      if (wr_en) begin
         case (paddr)
            `EPM_OFF_ISCFG: begin
               // only the action and traffic class fields take writes
               r_d.action = pwdata[`EPM_ACT_MSB:`EPM_ACT_LSB];
               r_d.tc     = pwdata[`EPM_TC_MSB:`EPM_TC_LSB];
            end
            `EPM_OFF_PMCAP: begin
               // device specific init writable only under unlock
               if (r_q.unlock) begin
                  r_d.dev_init = pwdata[`EPM_DEV_INIT_BIT];
               end
            end
            `EPM_OFF_ICLR: begin
               if (pwdata[`EPM_EVT_BIT]) begin
                  r_d.status = 1'b0;
               end
            end
            `EPM_OFF_IEN: r_d.enable = pwdata[`EPM_EVT_BIT];
            `EPM_OFF_CTRL: begin
               r_d.msi_en   = pwdata[`EPM_CTRL_MSI_EN];
               r_d.intx_dis = pwdata[`EPM_CTRL_INTX_DIS];
               r_d.unlock   = pwdata[`EPM_CTRL_UNLOCK];
            end
            default: r_d.action = r_q.action;
         endcase
      end
      // event set wins over a same-cycle clear so no edge is lost
      if (evt_pulse) begin
         r_d.status = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '{action: `EPM_ACT_RST, tc: `EPM_TC_RST, dev_init: `EPM_DEV_INIT_RST,
                  status: 1'b0, enable: 1'b0, msi_en: 1'b0, intx_dis: 1'b0,
                  unlock: 1'b0, prdata: 32'h0000_0000};
      end else begin
         r_q <= r_d;
      end
   end

   // action is taken live; software keeps it stable while status is set
   assign msg.status   = r_q.status;
   assign msg.action   = r_q.action;
   assign msg.tc       = r_q.tc;
   assign msg.msi_en   = r_q.msi_en;
   assign msg.intx_dis = r_q.intx_dis;

   // level interrupt, high while an enabled status bit is set
   assign irq           = r_q.status & r_q.enable;
   assign prdata        = r_q.prdata;
   assign msi_req       = msg.msi_req;
   assign msi_tc        = msg.msi_tc;
   assign intx_assert   = msg.intx_assert;
   assign intx_deassert = msg.intx_deassert;
   assign intx_pin      = msg.intx_pin;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // read access to the pm header, as the master samples it
   logic pm_rd;
   assign pm_rd = access_ph & ~pwrite & (paddr == `EPM_OFF_PMCAP);

   cap_ident_a: assert property (pm_rd |-> prdata[7:0] == 8'h01)
      else $error("capability id not one");
   next_ptr_a: assert property (pm_rd |-> prdata[15:8] == 8'h00)
      else $error("next pointer not zero");
   pm_version_a: assert property (pm_rd |-> prdata[18:16] == 3'h2)
      else $error("pm version not two");
   evt_clk_resv_a: assert property (pm_rd |-> prdata[20:19] == 2'h0)
      else $error("bits 20:19 not zero");
   aux_current_a: assert property (pm_rd |-> prdata[24:22] == 3'h0)
      else $error("aux current not zero");
   d1_d2_a: assert property (pm_rd |-> prdata[26:25] == 2'h0)
      else $error("d1 or d2 support not zero");
   pme_support_a: assert property (pm_rd |-> prdata[31:27] == 5'h00)
      else $error("pme support not zero");
   dev_init_lock_a: assert property (!r_q.unlock |=> $stable(r_q.dev_init))
      else $error("init bit changed while locked");
   cfg_resv_a: assert property (access_ph && !pwrite && paddr == `EPM_OFF_ISCFG
      |-> prdata[28:21] == 8'h00 && prdata[17:0] == 18'h00000)
      else $error("reserved config bits not zero");
   set_wins_a: assert property (evt_pulse |=> r_q.status ##1 (msg.status || $past(wr_en)))
      else $error("event lost against clear");

   // write strobes as the bank sees them, for the field checks below
   logic cfg_wr;
   logic clr_wr;
   assign cfg_wr = wr_en & (paddr == `EPM_OFF_ISCFG);
   assign clr_wr = wr_en & (paddr == `EPM_OFF_ICLR) & pwdata[`EPM_EVT_BIT];

   // a config write lands in the action and class fields at the access edge
   action_write_a: assert property (cfg_wr |=> r_q.action == $past(pwdata[20:18]))
      else $error("action field write lost");
   tc_write_a: assert property (cfg_wr |=> r_q.tc == $past(pwdata[31:29]))
      else $error("traffic class write lost");
   // status is sticky; only a clear write without a new event drops it
   status_hold_a: assert property (r_q.status && !clr_wr |=> r_q.status)
      else $error("status dropped without clear");
   status_clear_a: assert property (clr_wr && !evt_pulse |=> !r_q.status)
      else $error("status not cleared");
   // unlocked header write reaches the init bit
   init_unlock_a: assert property (wr_en && paddr == `EPM_OFF_PMCAP && r_q.unlock
      |=> r_q.dev_init == $past(pwdata[21]))
      else $error("init bit write lost while unlocked");
   // gating bits of the message generator come from the control word
   ctrl_write_a: assert property (wr_en && paddr == `EPM_OFF_CTRL
      |=> r_q.msi_en == $past(pwdata[0]) && r_q.intx_dis == $past(pwdata[1]))
      else $error("control bits write lost");
endmodule : epm_regs

// ---- rtl/epm_params.svh ----
// offsets, field positions, reset values and codes of the endpoint irq / pm register bank
`ifndef EPM_PARAMS_SVH
`define EPM_PARAMS_SVH

// register byte offsets on the apb bus
`define EPM_OFF_PMCAP      12'h0f0
`define EPM_OFF_ISCFG      12'h0e0
`define EPM_OFF_ISTS       12'h0e4
`define EPM_OFF_ICLR       12'h0e8
`define EPM_OFF_IEN        12'h0ec
`define EPM_OFF_CTRL       12'h0d0

// interrupt signalling configuration fields
`define EPM_ACT_LSB        18
`define EPM_ACT_MSB        20
`define EPM_TC_LSB         29
`define EPM_TC_MSB         31
`define EPM_ACT_RST        3'h0
`define EPM_TC_RST         3'h0

// action codes of the far-side power change field
`define EPM_ACT_MASKED     3'h0
`define EPM_ACT_MSI        3'h1
`define EPM_ACT_INTA       3'h2
`define EPM_ACT_INTC       3'h4
`define EPM_ACT_INTD       3'h5

// legacy interrupt pin codes carried with each message
`define EPM_PIN_A          2'h0
`define EPM_PIN_C          2'h2
`define EPM_PIN_D          2'h3

// power management capability header constants
`define EPM_CAP_IDENT      8'h01
`define EPM_NEXT_PTR       8'h00
`define EPM_PMVER          3'h2
`define EPM_DEV_INIT_BIT   21
`define EPM_DEV_INIT_RST   1'h0

// control register bits
`define EPM_CTRL_MSI_EN    0
`define EPM_CTRL_INTX_DIS  1
`define EPM_CTRL_UNLOCK    2

// status, clear and enable bit of the far-side power change event
`define EPM_EVT_BIT        0

`endif

// ---- rtl/epm_pkg.sv ----
// types shared by the endpoint irq / pm register bank modules
package epm_pkg;

   typedef enum logic {
      intx_idle,
      intx_asserted
   } epm_intx_st_t;

   // state of the message generator
   typedef struct packed {
      epm_intx_st_t st;
      logic         prev;
      logic         msi_req;
      logic [2:0]   msi_tc;
      logic         asrt;
      logic         deas;
      logic [1:0]   pin;
   } epm_gen_t;

   // state of the register bank
   typedef struct packed {
      logic [2:0]   action;
      logic [2:0]   tc;
      logic         dev_init;
      logic         status;
      logic         enable;
      logic         msi_en;
      logic         intx_dis;
      logic         unlock;
      logic [31:0]  prdata;
   } epm_regs_t;

endpackage : epm_pkg

// ---- rtl/epm_msg_if.sv ----
// carrier between register bank and interrupt message generator
`timescale 1ns/1ps
interface epm_msg_if;
   logic       status;
   logic [2:0] action;
   logic [2:0] tc;
   logic       msi_en;
   logic       intx_dis;
   logic       msi_req;
   logic [2:0] msi_tc;
   logic       intx_assert;
   logic       intx_deassert;
   logic [1:0] intx_pin;

   modport regs (output status, output action, output tc, output msi_en, output intx_dis,
                 input msi_req, input msi_tc, input intx_assert, input intx_deassert,
                 input intx_pin);
   modport gen  (input status, input action, input tc, input msi_en, input intx_dis,
                 output msi_req, output msi_tc, output intx_assert, output intx_deassert,
                 output intx_pin);
endinterface : epm_msg_if

// ---- rtl/epm_sync.sv ----
// two-flop synchroniser with rising-edge pulse for the far-side power change pin
`timescale 1ns/1ps
module epm_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      rise_pulse
);
   logic [2:0] s_q;
   logic [2:0] s_d;

   // s_q[0] is only read by s_q[1]; edge detect looks at the later stages
   always_comb begin
      s_d = {s_q[1], s_q[0], async_in};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= 3'h0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rise_pulse = s_q[1] & ~s_q[2];
endmodule : epm_sync

// ---- rtl/epm_msg_gen.sv ----
// turns status edges into msi or legacy interrupt messages
`timescale 1ns/1ps
module epm_msg_gen (
   input  wire logic pclk,
   input  wire logic presetn,
   epm_msg_if.gen    m
);
   epm_pkg::epm_gen_t g_q;
   epm_pkg::epm_gen_t g_d;
   logic              rise;
   logic              fall;
   logic              is_intx;
   logic [1:0]        pin_sel;

   assign rise = m.status & ~g_q.prev;
   assign fall = ~m.status & g_q.prev;

   // action decode; code 3 and 6..7 do nothing
   always_comb begin
      is_intx = 1'b1;
      pin_sel = `EPM_PIN_A;
      case (m.action)
         `EPM_ACT_INTA: pin_sel = `EPM_PIN_A;
         `EPM_ACT_INTC: pin_sel = `EPM_PIN_C;
         `EPM_ACT_INTD: pin_sel = `EPM_PIN_D;
         default:       is_intx = 1'b0;
      endcase
   end

   // act on set, negate on clear
   always_comb begin
      g_d         = g_q;
      g_d.prev    = m.status;
      g_d.msi_req = 1'b0;
      g_d.asrt    = 1'b0;
      g_d.deas    = 1'b0;
      // msi only while msi enable is set
      if (rise && m.action == `EPM_ACT_MSI && m.msi_en) begin
         g_d.msi_req = 1'b1;
         // traffic class tagged on each msi
         g_d.msi_tc  = m.tc;
      end
      case (g_q.st)
         epm_pkg::intx_idle: begin
            // assertion suppressed while legacy irqs disabled
            if (rise && is_intx && !m.intx_dis) begin
               g_d.asrt = 1'b1;
               g_d.pin  = pin_sel;
               g_d.st   = epm_pkg::intx_asserted;
            end
         end
         epm_pkg::intx_asserted: begin
            // negation uses the pin that was asserted
            if (fall) begin
               g_d.deas = ~m.intx_dis;
               g_d.st   = epm_pkg::intx_idle;
            end
         end
         default: g_d.st = epm_pkg::intx_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         g_q <= '{st: epm_pkg::intx_idle, prev: 1'b0, msi_req: 1'b0, msi_tc: `EPM_TC_RST,
                  asrt: 1'b0, deas: 1'b0, pin: `EPM_PIN_A};
      end else begin
         g_q <= g_d;
      end
   end

   assign m.msi_req       = g_q.msi_req;
   assign m.msi_tc        = g_q.msi_tc;
   assign m.intx_assert   = g_q.asrt;
   assign m.intx_deassert = g_q.deas;
   assign m.intx_pin      = g_q.pin;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   msi_on_rise_a: assert property ($rose(m.status) && m.action == `EPM_ACT_MSI && m.msi_en
      |=> m.msi_req)
      else $error("msi not sent on status rise");
   msi_gate_a: assert property (m.msi_req |-> $past(m.msi_en))
      else $error("msi sent while msi disabled");
   intx_gate_a: assert property (m.intx_assert || m.intx_deassert |-> !$past(m.intx_dis))
      else $error("intx message while legacy irqs disabled");
   // negation follows the first cycle of a cleared status while an assertion is open
   intx_negate_a: assert property ($fell(m.status) && g_q.st == epm_pkg::intx_asserted
      |=> m.intx_deassert || $past(m.intx_dis))
      else $error("intx negation missing after status cleared");
   msi_tc_a: assert property (m.msi_req |-> m.msi_tc == $past(m.tc))
      else $error("msi traffic class mismatch");
endmodule : epm_msg_gen

// ---- bench/epm_host_model.sv ----
// host-side sink that counts msi and legacy interrupt messages
`timescale 1ns/1ps
module epm_host_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       msi_req,
   input  wire logic [2:0] msi_tc,
   input  wire logic       intx_assert,
   input  wire logic       intx_deassert,
   input  wire logic [1:0] intx_pin,
   output logic      [7:0] n_msi,
   output logic      [7:0] n_asrt,
   output logic      [7:0] n_deas,
   output logic      [2:0] last_tc,
   output logic      [1:0] last_pin
);
   // message pulses stand one cycle, so each is taken at the edge it is seen
   // count messages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_msi    <= 8'h00;
         n_asrt   <= 8'h00;
         n_deas   <= 8'h00;
         last_tc  <= 3'h0;
         last_pin <= 2'h0;
      end else begin
         if (msi_req === 1'b1) begin
            n_msi   <= n_msi + 8'h01;
            last_tc <= msi_tc;
         end
         if (intx_assert === 1'b1) begin
            n_asrt   <= n_asrt + 8'h01;
            last_pin <= intx_pin;
         end
         if (intx_deassert === 1'b1) begin
            n_deas <= n_deas + 8'h01;
         end
      end
   end
endmodule : epm_host_model

// ---- bench/test_epm_regs.sv ----
// self-checking bench for the endpoint irq / pm register bank
`timescale 1ns/1ps
`include "epm_params.svh"
module test_epm_regs;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pin = 1'b0;
   logic        irq, msi_req, intx_assert, intx_deassert;
   logic [2:0]  msi_tc, last_tc;
   logic [1:0]  intx_pin, last_pin;
   logic [7:0]  n_msi, n_asrt, n_deas;
   int          fail_count = 0;
   int          n_compared = 0;

   epm_regs epm_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .far_power_change(pin), .irq(irq), .msi_req(msi_req),
      .msi_tc(msi_tc), .intx_assert(intx_assert), .intx_deassert(intx_deassert),
      .intx_pin(intx_pin));
   epm_host_model epm_host_model_inst (.pclk(pclk), .presetn(presetn), .msi_req(msi_req),
      .msi_tc(msi_tc), .intx_assert(intx_assert), .intx_deassert(intx_deassert),
      .intx_pin(intx_pin), .n_msi(n_msi), .n_asrt(n_asrt), .n_deas(n_deas),
      .last_tc(last_tc), .last_pin(last_pin));

   // 50 mhz clock
   always #10 pclk = ~pclk;

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
      chk_bit("write error", 1'b0, err);
   endtask : wr

   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      chk_word(what, exp, rd);
   endtask : rd_chk

   // one far-side power change event and its clear, with message counting
   task automatic ev(input logic [2:0] act, input logic [2:0] tc, input logic [2:0] ctl,
                     input logic en);
      logic [7:0] m0, a0, d0;
      logic       e_msi, e_x;
      logic [1:0] e_pin;
      e_msi = (act == `EPM_ACT_MSI) && ctl[`EPM_CTRL_MSI_EN];
      e_x = (act == `EPM_ACT_INTA || act == `EPM_ACT_INTC || act == `EPM_ACT_INTD)
            && !ctl[`EPM_CTRL_INTX_DIS];
      e_pin = (act == `EPM_ACT_INTA) ? `EPM_PIN_A :
              (act == `EPM_ACT_INTC) ? `EPM_PIN_C : `EPM_PIN_D;
      wr(`EPM_OFF_CTRL, {29'h0, ctl});
      wr(`EPM_OFF_IEN, {31'h0, en});
      wr(`EPM_OFF_ISCFG, {tc, 8'h00, act, 18'h0});
      m0 = n_msi;
      a0 = n_asrt;
      d0 = n_deas;
      @(posedge pclk);
      pin <= 1'b1;
      repeat (6) @(posedge pclk);
      pin <= 1'b0;
      // status is sticky after the pin falls
      rd_chk("status set", `EPM_OFF_ISTS, 32'h1);
      chk_bit("irq level", en, irq);
      chk_word("msi count", {31'h0, e_msi}, {24'h0, n_msi - m0});
      chk_word("assert count", {31'h0, e_x}, {24'h0, n_asrt - a0});
      if (e_msi) chk_word("msi class", {29'h0, tc}, {29'h0, last_tc});
      if (e_x) chk_word("intx pin", {30'h0, e_pin}, {30'h0, last_pin});
      wr(`EPM_OFF_ICLR, 32'h1);
      repeat (3) @(posedge pclk);
      chk_word("negate count", {31'h0, e_x}, {24'h0, n_deas - d0});
      rd_chk("status clear", `EPM_OFF_ISTS, 32'h0);
      chk_bit("irq low", 1'b0, irq);
   endtask : ev

   // whole run takes a few hundred cycles; the limit leaves wide margin
   initial begin
      #400000;
      fail_count++;
      close_out();
   end

   // main sequence
   initial begin
      logic [31:0] rd;
      logic        err;
      logic [31:0] pm;
      pm = {10'h000, 1'b0, 2'h0, `EPM_PMVER, `EPM_NEXT_PTR, `EPM_CAP_IDENT};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("pm header reset", `EPM_OFF_PMCAP, pm);
      rd_chk("config reset", `EPM_OFF_ISCFG, 32'h0);
      // locked header ignores every write
      wr(`EPM_OFF_PMCAP, 32'hffffffff);
      rd_chk("pm header locked", `EPM_OFF_PMCAP, pm);
      wr(`EPM_OFF_CTRL, 32'h4);
      wr(`EPM_OFF_PMCAP, 32'hffffffff);
      rd_chk("pm header unlocked", `EPM_OFF_PMCAP, pm | 32'h00200000);
      wr(`EPM_OFF_PMCAP, 32'h0);
      rd_chk("init bit cleared", `EPM_OFF_PMCAP, pm);
      // reserved config bits stay zero
      wr(`EPM_OFF_ISCFG, 32'hffffffff);
      rd_chk("config fields", `EPM_OFF_ISCFG, 32'he01c0000);
      wr(`EPM_OFF_ISCFG, 32'h0);
      rd_chk("clear reads zero", `EPM_OFF_ICLR, 32'h0);
      apb(1'b0, 12'h0fc, 32'h0, rd, err);
      chk_bit("unmapped error", 1'b1, err);
      chk_word("unmapped data", 32'h0, rd);
      // slave never stalls, so ready stands high between transfers too
      chk_bit("ready", 1'b1, pready);
      // every action code, msi enabled and legacy allowed
      for (int a = 0; a < 8; a++) ev(a[2:0], a[2:0], 3'h1, 1'b1);
      ev(`EPM_ACT_MSI, 3'h7, 3'h1, 1'b1);
      ev(`EPM_ACT_MSI, 3'h5, 3'h0, 1'b0);
      ev(`EPM_ACT_INTC, 3'h2, 3'h3, 1'b1);
      ev(`EPM_ACT_INTD, 3'h0, 3'h0, 1'b0);
      close_out();
   end
endmodule : test_epm_regs
